// File: logic/added_instr_exec.sv
// executor for the added instructions: bit test branch, bank switching, traps
module added_instr_exec (
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    // instruction issue from decoder
    input  wire logic                         issue_valid,
    input  wire added_exec_pkg::issue_s       issue,
    // live stack values of the current bank
    input  wire logic [15:0]                  cur_stack_segment,
    input  wire logic [15:0]                  cur_stack_pointer_reg,
    // special function register access
    input  wire logic [7:0]                   sfr_rdata,
    output logic [7:0]                        sfr_addr,
    output logic [7:0]                        sfr_wdata,
    output logic                              sfr_we,
    // results
    output added_exec_pkg::redirect_s         redirect,
    output logic                              stack_load,
    output logic [15:0]                       stack_segment_out,
    output logic [15:0]                       stack_pointer_out,
    output logic [2:0]                        active_bank,
    output logic                              eoi_pulse,
    output logic                              io_trap,
    output logic                              float_trap,
    output logic                              deep_standby,
    output logic                              done
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    // three phases: wait for issue, sfr read, finish and report
    typedef enum logic [1:0] {IDLE, SFR_READ, FINISH} exec_state_e;
    exec_state_e state_q;       // sequencing state
    exec_state_e state_d;
    added_exec_pkg::issue_s issue_q;   // latched instruction
    logic [2:0] bank_q;                // active bank
    logic [2:0] prev_bank_q;           // bank before the latest switch
    // special function register address and write data, held between instructions; the write strobe is a one-cycle pulse
    logic [7:0] sfr_addr_q;
    logic [7:0] sfr_wdata_q;
    logic sfr_we_q;
    // control transfer and stack results
    added_exec_pkg::redirect_s redirect_q;
    logic stack_load_q;
    logic [15:0] ss_out_q;
    logic [15:0] sp_out_q;
    // one-cycle event pulses and the sticky standby level
    logic eoi_q;
    logic io_trap_q;
    logic float_trap_q;
    logic standby_q;
    logic done_q;

    ////////////////////////////////////////////////////////////////////////////
    // bank store wiring
    // write port from the save and copy-out logic, read port from decode
    logic bs_wr_en;
    logic [2:0] bs_wr_idx;
    added_exec_pkg::bank_ctx_s bs_wr_data;
    logic [2:0] bs_rd_idx;
    added_exec_pkg::bank_ctx_s bs_rd;

    // context storage; vector pc entries read as zero after reset
    bank_store #(.NB(added_exec_pkg::NUM_BANKS)) u_banks (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (bs_wr_en),
        .wr_idx  (bs_wr_idx),
        .wr_data (bs_wr_data),
        .rd_idx  (bs_rd_idx),
        .rd_data (bs_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode
    // the latched op drives the decodes here; only the next state decodes the live issue.op
    wire accept = issue_valid && (state_q == IDLE);
    wire added_exec_pkg::added_op_e op = issue_q.op;
    // operand low bits pick the bank; all 8 codes are valid
    wire [2:0] operand_bank = issue_q.reg_operand[added_exec_pkg::BANK_W-1:0];
    wire is_call = (op == added_exec_pkg::OP_BANK_SWITCH_CALL);
    wire is_task = (op == added_exec_pkg::OP_TASK_SWITCH);
    wire is_ret = (op == added_exec_pkg::OP_BANK_RETURN);
    wire is_cin = (op == added_exec_pkg::OP_STACK_COPY_IN);
    wire is_cout = (op == added_exec_pkg::OP_STACK_COPY_OUT);
    // copy-in and bank return read the bank before the switch
    // call, task and copy-out read the operand bank; the read port is idle
    // otherwise, so copy-out can keep the fields it does not own
    assign bs_rd_idx = (is_cin || is_ret) ? prev_bank_q :
                       (is_call || is_task || is_cout) ? operand_bank : bank_q;
    // selected bit test
    wire bit_set = sfr_rdata[issue_q.bit_selector];
    // short target: sign-extend and add to end-of-instruction pc
    wire [15:0] disp_ext = {{8{issue_q.disp[7]}}, issue_q.disp};
    wire [15:0] short_target = issue_q.next_pc + disp_ext;
    // io break flag zero blocks io
    wire io_brk = issue_q.cur_psw[added_exec_pkg::IO_BRK_BIT];
    // copy-out stores current stack into operand bank; call/task save current
    wire save_cur = is_call || is_task;

    ////////////////////////////////////////////////////////////////////////////
    // bank store write: save current context or stack copy-out
    always_comb begin
        // defaults: no write, harmless index and data
        bs_wr_en = 1'b0;
        bs_wr_idx = bank_q;
        bs_wr_data = bs_rd;
        if (state_q == FINISH && save_cur) begin
            // remember return point in the bank being left (used by bank return)
            bs_wr_en = 1'b1;
            bs_wr_idx = bank_q;
            bs_wr_data = '0;
            bs_wr_data.program_segment = issue_q.cur_ps;
            bs_wr_data.saved_pc = issue_q.next_pc;
            bs_wr_data.saved_psw = issue_q.cur_psw;
            bs_wr_data.stack_segment = cur_stack_segment;
            bs_wr_data.stack_pointer_reg = cur_stack_pointer_reg;
        end else if (state_q == FINISH && is_cout) begin
            // read-modify-write through the shared read port: only the
            // stack fields change, the bank's vector and saved pc survive
            bs_wr_en = 1'b1;
            bs_wr_idx = operand_bank;
            bs_wr_data = bs_rd;
            bs_wr_data.stack_segment = cur_stack_segment;
            bs_wr_data.stack_pointer_reg = cur_stack_pointer_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    // bit test spends one cycle reading the sfr; the rest finish at once
    // issue_valid outside IDLE is dropped: the core must hold and re-present
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IDLE: begin
                if (accept) begin
                    state_d = (issue.op == added_exec_pkg::OP_BIT_TEST_CLEAR) ? SFR_READ : FINISH;
                end
            end
            SFR_READ: state_d = FINISH;
            FINISH: state_d = IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer and latched instruction
    // fields are latched at accept so the core may change issue afterwards
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= IDLE;
            issue_q <= '0;
        end else begin
            state_q <= state_d;
            if (accept) begin
                issue_q <= issue;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bank tracking
    // only call, task switch and bank return move the active bank
    // prev bank is swapped on return so a second return goes back again
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bank_q <= added_exec_pkg::RESET_BANK;
            prev_bank_q <= added_exec_pkg::RESET_BANK;
        end else if (state_q == FINISH && save_cur) begin
            bank_q <= operand_bank;
            prev_bank_q <= bank_q;
        end else if (state_q == FINISH && is_ret) begin
            bank_q <= prev_bank_q;
            prev_bank_q <= bank_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // special function register bit test and clear
    // write strobe is a single pulse; address stays for the read data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sfr_addr_q <= 8'h00;
            sfr_wdata_q <= 8'h00;
            sfr_we_q <= 1'b0;
        end else begin
            sfr_we_q <= 1'b0;
            if (accept) begin
                // address taken with the instruction, read data follows
                sfr_addr_q <= issue.sfr_addr;
            end
            if (state_q == SFR_READ && bit_set) begin
                // clear only the selected bit
                sfr_wdata_q <= sfr_rdata & ~(8'h01 << issue_q.bit_selector);
                sfr_we_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control transfer, status word and stack results
    // jump and psw_load are pulses; pc, ps and stack words hold
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            redirect_q <= '0;
            stack_load_q <= 1'b0;
            ss_out_q <= added_exec_pkg::RESET_WORD;
            sp_out_q <= added_exec_pkg::RESET_WORD;
        end else begin
            redirect_q.jump <= 1'b0;
            redirect_q.psw_load <= 1'b0;
            stack_load_q <= 1'b0;
            if (state_q == SFR_READ) begin
                // taken only if set; psw never loaded here
                redirect_q.jump <= bit_set;
                redirect_q.pc <= short_target;
                redirect_q.ps <= issue_q.cur_ps;
            end else if (state_q == FINISH && is_call) begin
                // new bank's vector entry and its stored segment
                redirect_q.jump <= 1'b1;
                redirect_q.pc <= bs_rd.vector_pc;
                redirect_q.ps <= bs_rd.program_segment;
            end else if (state_q == FINISH && is_task) begin
                // resume where the new bank last left off
                redirect_q.jump <= 1'b1;
                redirect_q.pc <= bs_rd.saved_pc;
                redirect_q.ps <= bs_rd.program_segment;
            end else if (state_q == FINISH && is_ret) begin
                // context saved in the bank being returned to
                redirect_q.jump <= 1'b1;
                redirect_q.psw_load <= 1'b1;
                redirect_q.pc <= bs_rd.saved_pc;
                redirect_q.ps <= bs_rd.program_segment;
                redirect_q.program_status_word <= bs_rd.saved_psw;
            end else if (state_q == FINISH && is_cin) begin
                // stack words of the bank left by the latest switch
                stack_load_q <= 1'b1;
                ss_out_q <= bs_rd.stack_segment;
                sp_out_q <= bs_rd.stack_pointer_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events: end notice, traps, standby, completion
    // the core decides which interrupt a trap raises; only the cause is flagged
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eoi_q <= 1'b0;
            io_trap_q <= 1'b0;
            float_trap_q <= 1'b0;
            standby_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            // end notice reaches the interrupt controller for one cycle
            eoi_q <= (state_q == FINISH) && (op == added_exec_pkg::OP_EOI_NOTICE);
            // io is suppressed while the break flag is clear; core takes the interrupt instead
            io_trap_q <= (state_q == FINISH) && (op == added_exec_pkg::OP_IO) && !io_brk;
            float_trap_q <= (state_q == FINISH) && (op == added_exec_pkg::OP_FLOAT_ESCAPE);
            // done closes every instruction, trapped or not
            done_q <= (state_q == FINISH);
            // standby is held until the core is reset
            if (state_q == FINISH && op == added_exec_pkg::OP_DEEP_STANDBY) begin
                standby_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    // no combinational path from issue back to the core
    assign sfr_addr = sfr_addr_q;
    assign sfr_wdata = sfr_wdata_q;
    assign sfr_we = sfr_we_q;
    assign redirect = redirect_q;
    assign stack_load = stack_load_q;
    assign stack_segment_out = ss_out_q;
    assign stack_pointer_out = sp_out_q;
    assign active_bank = bank_q;
    assign eoi_pulse = eoi_q;
    assign io_trap = io_trap_q;
    assign float_trap = float_trap_q;
    assign deep_standby = standby_q;
    assign done = done_q;
endmodule : added_instr_exec

// File: logic/added_exec_pkg.sv
// package: encodings, field sizes and carriers for the added-instruction executor
package added_exec_pkg;
    localparam int BANK_W      = 3;           // bank index width
    localparam int NUM_BANKS   = 8;           // one bank per index value
    localparam int SFR_AW      = 8;           // special function register address width
    localparam int BIT_SEL_W   = 3;           // bit selector width
    localparam int WORD_W      = 16;          // core word width
    localparam int ADDR_W      = 20;          // physical address width
    localparam int SEG_SHIFT   = 4;           // segment to physical shift
    localparam logic [2:0] RESET_BANK = 3'h7; // bank active after reset
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam int IO_BRK_BIT  = 1;           // position of io break flag in status word

    // operation decoded by the upstream instruction decoder
    typedef enum logic [3:0] {
        OP_NONE, OP_BIT_TEST_CLEAR, OP_BANK_RETURN, OP_EOI_NOTICE, OP_DEEP_STANDBY,
        OP_BANK_SWITCH_CALL, OP_TASK_SWITCH, OP_STACK_COPY_IN, OP_STACK_COPY_OUT,
        OP_IO, OP_FLOAT_ESCAPE
    } added_op_e;

    // one issued instruction
    typedef struct packed {
        added_op_e        op;
        logic [7:0]       sfr_addr;
        logic [2:0]       bit_selector;
        logic [7:0]       disp;     // signed short displacement
        logic [15:0]      reg_operand;
        logic [15:0]      next_pc;  // pc at end of instruction
        logic [15:0]      cur_ps;
        logic [15:0]      cur_psw;
    } issue_s;

    // saved context of one register bank
    typedef struct packed {
        logic [15:0] program_segment;
        logic [15:0] vector_pc;
        logic [15:0] saved_pc;
        logic [15:0] saved_psw;
        logic [15:0] stack_segment;
        logic [15:0] stack_pointer_reg;
    } bank_ctx_s;

    // resulting control transfer
    typedef struct packed {
        logic        jump;
        logic [15:0] pc;
        logic [15:0] ps;
        logic        psw_load;
        logic [15:0] program_status_word;
    } redirect_s;
endpackage : added_exec_pkg

// File: logic/bank_store.sv
// register bank context storage, one entry per bank index
module bank_store #(
    parameter int NB = added_exec_pkg::NUM_BANKS
) (
    // clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // write port
    input  wire logic                              wr_en,
    input  wire logic [added_exec_pkg::BANK_W-1:0] wr_idx,
    input  wire added_exec_pkg::bank_ctx_s         wr_data,
    // read port
    input  wire logic [added_exec_pkg::BANK_W-1:0] rd_idx,
    output added_exec_pkg::bank_ctx_s              rd_data
);
    // flip-flop array, every index maps to exactly one entry
    added_exec_pkg::bank_ctx_s mem_q [NB];

    assign rd_data = mem_q[rd_idx];

    // single write port keeps one driver per entry
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NB; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end
endmodule : bank_store

// File: test/added_exec_sva.sv
// checker for the added-instruction executor, bound to its ports
module added_exec_sva (
    // clock and reset
    input wire logic                      clk_sys,
    input wire logic                      rst,
    // issue side and sfr read data
    input wire added_exec_pkg::issue_s    issue,
    input wire logic [7:0]                sfr_rdata,
    // outputs under watch
    input wire logic [7:0]                sfr_wdata,
    input wire logic                      sfr_we,
    input wire added_exec_pkg::redirect_s redirect,
    input wire logic                      stack_load,
    input wire logic [2:0]                active_bank,
    input wire logic                      eoi_pulse,
    input wire logic                      io_trap,
    input wire logic                      float_trap,
    input wire logic                      deep_standby,
    input wire logic                      done
);
    // one clock domain, so one default clock and disable
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // clear write lands one cycle ahead of completion
    sequence s_clear_then_done;
        sfr_we ##1 done;
    endsequence
    // taken bit test branch, seen on its jump pulse
    sequence s_btc_jump;
        redirect.jump && issue.op == added_exec_pkg::OP_BIT_TEST_CLEAR;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_clear_bit_value: assert property (sfr_we |-> sfr_rdata[issue.bit_selector] &&
        sfr_wdata == (sfr_rdata & ~(8'h01 << issue.bit_selector))) else $error("bad clear");
    a_write_then_done: assert property (sfr_we |-> s_clear_then_done)
        else $error("write not followed by done");
    a_branch_target: assert property (s_btc_jump |-> redirect.pc ==
        issue.next_pc + {{8{issue.disp[7]}}, issue.disp}) else $error("bad short target");
    a_status_kept: assert property (redirect.psw_load |->
        issue.op != added_exec_pkg::OP_BIT_TEST_CLEAR) else $error("bit test wrote status");
    a_eoi_with_done: assert property (eoi_pulse |-> done &&
        issue.op == added_exec_pkg::OP_EOI_NOTICE) else $error("stray end notice");
    a_io_trap_cause: assert property (io_trap |-> done && issue.op == added_exec_pkg::OP_IO &&
        !issue.cur_psw[added_exec_pkg::IO_BRK_BIT]) else $error("io trap without cause");
    a_float_trap_cause: assert property (float_trap |-> done &&
        issue.op == added_exec_pkg::OP_FLOAT_ESCAPE) else $error("stray float trap");
    a_standby_sticky: assert property (deep_standby |=> deep_standby)
        else $error("standby dropped");
    a_standby_cause: assert property ($rose(deep_standby) |->
        issue.op == added_exec_pkg::OP_DEEP_STANDBY) else $error("standby without cause");
    a_call_bank: assert property (done && issue.op == added_exec_pkg::OP_BANK_SWITCH_CALL |->
        ##[0:1] active_bank == issue.reg_operand[2:0]) else $error("wrong bank after call");
    a_call_jumps: assert property (done && issue.op == added_exec_pkg::OP_BANK_SWITCH_CALL |->
        redirect.jump) else $error("call did not jump");
    a_stack_load_cause: assert property (stack_load |-> done &&
        issue.op == added_exec_pkg::OP_STACK_COPY_IN) else $error("stray stack load");
endmodule : added_exec_sva

bind added_instr_exec added_exec_sva u_sva (.clk_sys, .rst, .issue, .sfr_rdata, .sfr_wdata,
    .sfr_we, .redirect, .stack_load, .active_bank, .eoi_pulse, .io_trap, .float_trap,
    .deep_standby, .done);

// File: test/tb.sv
// self-checking bench for the added-instruction executor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      clk_sys = 1'b0;
    logic                      rst = 1'b1;
    logic                      issue_valid = 1'b0;
    added_exec_pkg::issue_s    issue = '0;
    added_exec_pkg::issue_s    ni;              // next instruction to issue
    logic [15:0]               cur_ss = 16'h0000;
    logic [15:0]               cur_sp = 16'h0000;
    logic [7:0]                sfr_q = 8'h00;   // the one modelled sfr
    logic [7:0]                sfr_addr, sfr_wdata, p;
    logic                      sfr_we, stack_load, eoi_pulse, io_trap, float_trap;
    logic                      deep_standby, done;
    added_exec_pkg::redirect_s redirect;
    logic [15:0]               ss_out, sp_out;
    logic [2:0]                active_bank;
    logic                      g_jump, g_eoi, g_io, g_fl, g_sl, g_psw, g_done; // seen pulses
    int                        n_errors = 0;
    int                        n_checks = 0;
    int                        cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    always #12.5 clk_sys = ~clk_sys;
    // sfr takes the clear write at the edge, so the read stays old until then
    always @(posedge clk_sys) begin
        if (sfr_we === 1'b1) sfr_q <= sfr_wdata;
    end
    // hang guard, far above the roughly 130 cycles the run needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            final_report();
        end
    end
    added_instr_exec uut (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid), .issue(issue),
        .cur_stack_segment(cur_ss), .cur_stack_pointer_reg(cur_sp), .sfr_rdata(sfr_q),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .redirect(redirect),
        .stack_load(stack_load), .stack_segment_out(ss_out), .stack_pointer_out(sp_out),
        .active_bank(active_bank), .eoi_pulse(eoi_pulse), .io_trap(io_trap),
        .float_trap(float_trap), .deep_standby(deep_standby), .done(done));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one request edge, then collect pulses until done; issue held for the checker
    task automatic run(input added_exec_pkg::issue_s i);
        {g_jump, g_eoi, g_io, g_fl, g_sl, g_psw, g_done} = '0;
        @(posedge clk_sys);
        issue <= i;
        issue_valid <= 1'b1;
        @(posedge clk_sys);
        issue_valid <= 1'b0;
        for (int k = 0; k < 8 && !g_done; k++) begin
            #1;
            g_jump |= (redirect.jump === 1'b1);
            g_psw |= (redirect.psw_load === 1'b1);
            g_eoi |= (eoi_pulse === 1'b1);
            g_io |= (io_trap === 1'b1);
            g_fl |= (float_trap === 1'b1);
            g_sl |= (stack_load === 1'b1);
            g_done |= (done === 1'b1);
            if (!g_done) @(posedge clk_sys);
        end
        check(g_done, 1'b1);
    endtask : run
    task automatic t_reset;
        @(posedge clk_sys);
        #1;
        check(active_bank, added_exec_pkg::RESET_BANK);
        check(deep_standby, 1'b0);
    endtask : t_reset
    // every selector, bit set and clear, both displacement extremes
    task automatic t_bit_test;
        for (int s = 0; s < 8; s++) begin
            for (int set = 0; set < 2; set++) begin
                p = set ? (8'h5A | (8'h01 << s)) : (8'h5A & ~(8'h01 << s));
                @(posedge clk_sys);
                sfr_q <= p;
                ni = '0;
                ni.op = added_exec_pkg::OP_BIT_TEST_CLEAR;
                ni.bit_selector = s[2:0];
                ni.disp = s[0] ? 8'h80 : 8'h7F;
                ni.next_pc = 16'h1000;
                ni.sfr_addr = 8'hE0 | 8'(s);
                run(ni);
                check(sfr_addr, ni.sfr_addr);
                check(sfr_q, set ? (p & ~(8'h01 << s)) : p);
                check(g_jump, set[0]);
                check(g_psw, 1'b0);
                if (set) check(redirect.pc, s[0] ? 16'h0F80 : 16'h107F);
            end
        end
    endtask : t_bit_test
    // end notice, float escape, io with break flag clear and set
    task automatic t_traps;
        ni = '0;
        ni.op = added_exec_pkg::OP_EOI_NOTICE;
        run(ni);
        check(g_eoi, 1'b1);
        ni.op = added_exec_pkg::OP_FLOAT_ESCAPE;
        run(ni);
        check(g_fl, 1'b1);
        ni.op = added_exec_pkg::OP_IO;
        run(ni);
        check(g_io, 1'b1);
        ni.cur_psw = 16'h0001 << added_exec_pkg::IO_BRK_BIT;
        run(ni);
        check(g_io, 1'b0);
    endtask : t_traps
    // call, stack copies, task switches there and back, bank return
    task automatic t_banks;
        @(posedge clk_sys);
        cur_ss <= 16'h5000;
        cur_sp <= 16'h0FFE;
        ni = '0;
        ni.op = added_exec_pkg::OP_BANK_SWITCH_CALL;
        ni.reg_operand = 16'hFFF3;
        ni.cur_ps = 16'hA000;
        ni.next_pc = 16'h0123;
        run(ni);
        check(g_jump, 1'b1);
        check(active_bank, 3'h3);
        check(redirect.pc, added_exec_pkg::RESET_WORD);
        check(redirect.ps, added_exec_pkg::RESET_WORD);
        @(posedge clk_sys);
        cur_ss <= 16'h6000;
        cur_sp <= 16'h0100;
        ni.op = added_exec_pkg::OP_STACK_COPY_IN;
        run(ni);
        check(g_sl, 1'b1);
        check({ss_out, sp_out}, 32'h50000FFE);
        // copy-out into the bank left by the call, so copy-in reads it back
        ni.op = added_exec_pkg::OP_STACK_COPY_OUT;
        ni.reg_operand = 16'h0007;
        run(ni);
        check(active_bank, 3'h3);
        ni.op = added_exec_pkg::OP_STACK_COPY_IN;
        run(ni);
        check({ss_out, sp_out}, 32'h60000100);
        ni.op = added_exec_pkg::OP_TASK_SWITCH;
        ni.reg_operand = 16'h0005;
        ni.cur_psw = 16'hF002;
        ni.cur_ps = 16'hB000;
        ni.next_pc = 16'h0456;
        run(ni);
        check(active_bank, 3'h5);
        ni.reg_operand = 16'h0003;
        run(ni);
        check(active_bank, 3'h3);
        check({redirect.ps, redirect.pc}, 32'hB0000456);
        ni.op = added_exec_pkg::OP_BANK_RETURN;
        run(ni);
        check(g_jump, 1'b1);
        check(active_bank, 3'h5);
        check({redirect.ps, redirect.pc}, 32'hB0000456);
        check({g_psw, redirect.program_status_word}, 17'h1F002);
    endtask : t_banks
    task automatic t_standby;
        ni = '0;
        ni.op = added_exec_pkg::OP_DEEP_STANDBY;
        run(ni);
        repeat (3) @(posedge clk_sys);
        #1;
        check(deep_standby, 1'b1);
        // a second reset in mid-run is the only way out of standby
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check(deep_standby, 1'b0);
        check(active_bank, added_exec_pkg::RESET_BANK);
    endtask : t_standby
    task automatic final_report;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_bit_test();
        t_traps();
        t_banks();
        t_standby();
        final_report();
    end
endmodule : tb
